//--- include/cvsr_consts.svh
// Offsets, field positions, reset values and decode constants of the setpoint bank
`ifndef CVSR_CONSTS_SVH
`define CVSR_CONSTS_SVH
// Printed offsets are not multiples of four: they are word indices
`define CVSR_IDX_LIMIT_SLEW 4'h5
`define CVSR_IDX_A_VOLT 4'h6
`define CVSR_IDX_B_VOLT 4'h7
`define CVSR_RST_LIMIT_SLEW 8'h1a
`define CVSR_RST_A_VOLT 8'h00
`define CVSR_RST_B_VOLT 8'h00
`define CVSR_LIMIT_MSB 5
`define CVSR_LIMIT_LSB 3
`define CVSR_RAMP_MSB 2
`define CVSR_RAMP_LSB 0
`define CVSR_LIMIT_RESERVED 3'h7
`define CVSR_RAMP_FIRST_VALID 3'h2
`define CVSR_CODE_FINE_LO 8'h14
`define CVSR_CODE_MID_LO 8'h18
`define CVSR_CODE_MID_HI 8'h9d
`define CVSR_CODE_COARSE_LO 8'h9e
// Decoded voltages in mV
`define CVSR_MV_FINE_BASE 12'h2bc
`define CVSR_MV_MID_BASE 12'h2df
`define CVSR_MV_COARSE_BASE 12'h58c
`define CVSR_MV_FINE_STEP 12'h00a
`define CVSR_MV_MID_STEP 12'h005
`define CVSR_MV_COARSE_STEP 12'h014
// Peak limit in mA: 1500 + 500 per code
`define CVSR_MA_BASE 13'h05dc
`define CVSR_MA_STEP 13'h01f4
`endif

//--- include/cvsr_pkg.sv
// Types shared by the setpoint register bank
package cvsr_pkg;
  typedef struct packed {
    logic [1:0] spare;
    logic [2:0] peak_limit;
    logic [2:0] ramp_speed;
  } cvsr_limit_slew_type;

  typedef struct packed {
    logic [12:0] peak_limit_ma;
    logic peak_limit_valid;
    logic [2:0] ramp_speed_code;
    logic ramp_speed_valid;
    logic [11:0] conv_a_mv;
    logic conv_a_valid;
    logic [11:0] conv_b_mv;
    logic conv_b_valid;
  } cvsr_analog_type;
endpackage

//--- design/cvsr_voltage_decode.sv
// Voltage setpoint code to millivolt decoder
`timescale 1ns/1ps
`default_nettype none
`include "cvsr_consts.svh"
module cvsr_voltage_decode
  import cvsr_pkg::*;
(
  input wire logic [7:0] code,
  output logic [11:0] millivolts,
  output logic valid
);
  logic [11:0] offs;

  always_comb
  begin
    offs = 12'h000;
    millivolts = 12'h000;
    valid = 1'b1;
    if (code < `CVSR_CODE_FINE_LO)
    begin
      // Reserved codes: keep the output at zero and flag it
      valid = 1'b0;
    end
    else if (code < `CVSR_CODE_MID_LO)
    begin
      // [RL8] 10 mV steps
      offs = {4'h0, code - `CVSR_CODE_FINE_LO};
      millivolts = 12'(`CVSR_MV_FINE_BASE + offs * `CVSR_MV_FINE_STEP);
    end
    else if (code <= `CVSR_CODE_MID_HI)
    begin
      // [RL9] 5 mV steps
      offs = {4'h0, code - `CVSR_CODE_MID_LO};
      millivolts = 12'(`CVSR_MV_MID_BASE + offs * `CVSR_MV_MID_STEP);
    end
    else
    begin
      // [RL10] 20 mV steps
      offs = {4'h0, code - `CVSR_CODE_COARSE_LO};
      millivolts = 12'(`CVSR_MV_COARSE_BASE + offs * `CVSR_MV_COARSE_STEP);
    end
  end
endmodule
`default_nettype wire

//--- design/cvsr_setpoint_regs.sv
// Converter setpoint register bank with APB slave and decoded analog settings
//
// Overview of operation
// [RL1] Peak limit in bits 5-3, 1.5 A to 4.5 A by 0.5 A; code 7 reserved
// [RL2] Peak limit may be rewritten while running and applies at once
// [RL3] Ramp speed in bits 2-0 for both ramps; codes 0, 1 reserved
// [RL4] Limit/ramp register at index 5, reset 1Ah, bits 7-6 reserved read-write
// [RL5] Converter A setpoint at index 6, full 8 bits, reset zero
// [RL6] Converter B setpoint at index 7, reset zero, same code table
// [RL7] Software must not write setpoint codes 00h through 13h
// [RL8] Codes 14h-17h give 0.70 V to 0.73 V in 10 mV steps
// [RL9] Codes 18h-9Dh give 0.735 V to 1.4 V in 5 mV steps
// [RL10] Codes 9Eh-FFh give 1.42 V to 3.36 V in 20 mV steps
// [RL11] Power-up contents come from one-time-programmable memory
// [RL12] A write lands next cycle; decoded setting follows from then on (the registered decoded outputs follow one cycle later)
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "cvsr_consts.svh"
module cvsr_setpoint_regs
  import cvsr_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  // One-time-programmable defaults, loaded once after reset release
  input wire logic otp_valid,
  input wire logic [7:0] otp_limit_slew,
  input wire logic [7:0] otp_a_volt,
  input wire logic [7:0] otp_b_volt,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Settings toward the converter control
  output cvsr_analog_type analog,
  output logic otp_loaded
);
  // ************************************************
  // Reset synchroniser and OTP input capture
  // ************************************************
  logic rst_meta;
  logic rst_sync_n;
  logic otp_valid_meta;
  logic otp_valid_sync;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // OTP valid arrives from another macro; the data are held stable while it is high
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      otp_valid_meta <= 1'b0;
      otp_valid_sync <= 1'b0;
    end
    else
    begin
      otp_valid_meta <= otp_valid;
      otp_valid_sync <= otp_valid_meta;
    end
  end

  // ************************************************
  // Address decode
  // ************************************************
  function automatic logic [1:0] reg_select(input logic [11:0] addr);
    logic [1:0] sel;
    sel = 2'h3;
    if (addr[1:0] == 2'h0)
    begin
      unique case (addr[5:2])
        `CVSR_IDX_LIMIT_SLEW: sel = 2'h0;
        `CVSR_IDX_A_VOLT: sel = 2'h1;
        `CVSR_IDX_B_VOLT: sel = 2'h2;
        default: sel = 2'h3;
      endcase
    end
    if (addr[11:6] != 6'h00)
    begin
      sel = 2'h3;
    end
    return sel;
  endfunction

  logic [1:0] sel;
  logic access;
  logic wr_ok;

  assign sel = reg_select(paddr);
  assign access = psel && penable && pready;
  assign wr_ok = access && pwrite && (sel != 2'h3) && pstrb[0];

  // ************************************************
  // Registers
  // ************************************************
  cvsr_limit_slew_type limit_slew;
  logic [7:0] a_volt;
  logic [7:0] b_volt;

  // Load once on the first rising edge of the synchronised OTP valid
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      otp_loaded <= 1'b0;
    end
    else if (otp_valid_sync)
    begin
      otp_loaded <= 1'b1;
    end
  end

  // A bus write in the load cycle loses; software is expected to wait for otp_loaded
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      // [RL4] reset value
      limit_slew <= `CVSR_RST_LIMIT_SLEW;
      // [RL5] [RL6] setpoints reset zero
      a_volt <= `CVSR_RST_A_VOLT;
      b_volt <= `CVSR_RST_B_VOLT;
    end
    else if (otp_valid_sync && !otp_loaded)
    begin
      // [RL11] OTP default load
      limit_slew <= otp_limit_slew;
      a_volt <= otp_a_volt;
      b_volt <= otp_b_volt;
    end
    else if (wr_ok)
    begin
      // [RL12] write lands next edge
      unique case (sel)
        2'h0: limit_slew <= pwdata[7:0];
        // [RL5] full-byte setpoint
        2'h1: a_volt <= pwdata[7:0];
        2'h2: b_volt <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ************************************************
  // APB answer: zero wait states
  // ************************************************
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      // Unmapped or misaligned address answers with an error
      pslverr <= psel && !penable && (sel == 2'h3);
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      unique case (sel)
        2'h0: prdata <= {24'h00_0000, limit_slew};
        2'h1: prdata <= {24'h00_0000, a_volt};
        2'h2: prdata <= {24'h00_0000, b_volt};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************
  // Decoded analog settings
  // ************************************************
  logic [11:0] next_a_mv;
  logic next_a_valid;
  logic [11:0] next_b_mv;
  logic next_b_valid;

  cvsr_voltage_decode u_dec_a (
    .code(a_volt),
    .millivolts(next_a_mv),
    .valid(next_a_valid)
  );

  // [RL6] same code table
  cvsr_voltage_decode u_dec_b (
    .code(b_volt),
    .millivolts(next_b_mv),
    .valid(next_b_valid)
  );

  // Registered so outputs come from flops; adds one cycle after the stored field
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      analog <= '0;
    end
    else
    begin
      // [RL1] peak limit decode
      analog.peak_limit_ma <=
        13'(`CVSR_MA_BASE + {10'h000, limit_slew.peak_limit} * `CVSR_MA_STEP);
      // [RL2] applied without disable
      analog.peak_limit_valid <= limit_slew.peak_limit != `CVSR_LIMIT_RESERVED;
      // [RL3] ramp code shared by both edges
      analog.ramp_speed_code <= limit_slew.ramp_speed;
      analog.ramp_speed_valid <= limit_slew.ramp_speed >= `CVSR_RAMP_FIRST_VALID;
      // [RL7] reserved codes flagged invalid
      analog.conv_a_mv <= next_a_mv;
      analog.conv_a_valid <= next_a_valid;
      analog.conv_b_mv <= next_b_mv;
      analog.conv_b_valid <= next_b_valid;
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  property p_write_lands;
    @(posedge mclk) disable iff (!rst_sync_n)
    (wr_ok && sel == 2'h1 && !(otp_valid_sync && !otp_loaded)) |=> a_volt == $past(pwdata[7:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("setpoint A write lost"); // [RL12]

  property p_decode_follows;
    @(posedge mclk) disable iff (!rst_sync_n)
    (wr_ok && sel == 2'h2 && pwdata[7:0] == 8'h9d && otp_loaded) |-> ##2 analog.conv_b_mv == 12'h578;
  endproperty
  a_decode_follows: assert property (p_decode_follows) else $error("B decode wrong"); // [RL9]

  property p_fine_range;
    @(posedge mclk) disable iff (!rst_sync_n)
    (a_volt == 8'h17) |=> analog.conv_a_mv == 12'h2da;
  endproperty
  a_fine_range: assert property (p_fine_range) else $error("fine top wrong"); // [RL8]

  property p_coarse_top;
    @(posedge mclk) disable iff (!rst_sync_n)
    (a_volt == 8'hff) |=> analog.conv_a_mv == 12'hd20;
  endproperty
  a_coarse_top: assert property (p_coarse_top) else $error("coarse top wrong"); // [RL10]

  property p_limit_decode;
    @(posedge mclk) disable iff (!rst_sync_n)
    (limit_slew.peak_limit == 3'h6) |=> analog.peak_limit_ma == 13'h1194 && analog.peak_limit_valid;
  endproperty
  a_limit_decode: assert property (p_limit_decode) else $error("limit decode wrong"); // [RL1]

  property p_limit_live;
    @(posedge mclk) disable iff (!rst_sync_n)
    (wr_ok && sel == 2'h0 && otp_loaded) |-> ##2 analog.peak_limit_ma ==
      13'(`CVSR_MA_BASE + {10'h000, $past(pwdata[5:3], 2)} * `CVSR_MA_STEP);
  endproperty
  a_limit_live: assert property (p_limit_live) else $error("limit not applied"); // [RL2]

  property p_ramp_valid;
    @(posedge mclk) disable iff (!rst_sync_n)
    // First edge out of reset still shows the cleared outputs
    $past(rst_sync_n) |-> analog.ramp_speed_valid == ($past(limit_slew.ramp_speed) >= 3'h2);
  endproperty
  a_ramp_valid: assert property (p_ramp_valid) else $error("ramp validity wrong"); // [RL3]

  property p_otp_load;
    @(posedge mclk) disable iff (!rst_sync_n)
    (otp_valid_sync && !otp_loaded) |=> b_volt == $past(otp_b_volt) && otp_loaded;
  endproperty
  a_otp_load: assert property (p_otp_load) else $error("OTP load missed"); // [RL11]

  property p_reserved_rw;
    @(posedge mclk) disable iff (!rst_sync_n)
    (wr_ok && sel == 2'h0 && !(otp_valid_sync && !otp_loaded)) |=> limit_slew.spare == $past(pwdata[7:6]);
  endproperty
  a_reserved_rw: assert property (p_reserved_rw) else $error("spare bits not stored"); // [RL4]

  property p_reserved_code;
    @(posedge mclk) disable iff (!rst_sync_n)
    (b_volt < 8'h14) |=> !analog.conv_b_valid;
  endproperty
  a_reserved_code: assert property (p_reserved_code) else $error("reserved code valid"); // [RL7]

  property p_zero_wait;
    @(posedge mclk) disable iff (!rst_sync_n)
    (psel && !penable) |=> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("APB answer late"); // [RL12]
endmodule
`default_nettype wire

//--- sim/cvsr_setpoint_regs_tb.sv
// Self-checking bench for the converter setpoint register bank
`timescale 1ns/1ps
`default_nettype none
`include "cvsr_consts.svh"
module cvsr_setpoint_regs_tb
  import cvsr_pkg::*;
;
  logic mclk, nrst, otp_valid, psel, penable, pwrite, pready, pslverr, otp_loaded, err;
  logic [7:0] otp_limit_slew, otp_a_volt, otp_b_volt, v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb;
  cvsr_analog_type analog;
  int mismatches, comparisons, n;
  // Software never writes a reserved setpoint code
  logic [7:0] vc [7] = '{8'h14, 8'h17, 8'h18, 8'h80, 8'h9d, 8'h9e, 8'hff};

  always #2.5 mclk = ~mclk;

  cvsr_setpoint_regs i_cvsr_setpoint_regs (.mclk(mclk), .nrst(nrst), .otp_valid(otp_valid),
    .otp_limit_slew(otp_limit_slew), .otp_a_volt(otp_a_volt), .otp_b_volt(otp_b_volt),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog(analog),
    .otp_loaded(otp_loaded));

  // ********************
  // Checking and closing
  // ********************
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // ********************
  // Bus cycles
  // ********************
  // Request stays put until pready is sampled high at a rising edge
  task apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      mismatches++;
      report_and_stop;
    end
  endtask

  task wr(input logic [3:0] idx, input logic [7:0] d);
    apb({6'h0, idx, 2'b00}, 1'b1, d, 4'hf);
  endtask

  task rd(input logic [3:0] idx, input logic [7:0] exp);
    apb({6'h0, idx, 2'b00}, 1'b0, 8'h00, 4'hf);
    check(rdata, {24'h0, exp}, "read data");
  endtask

  function automatic logic [31:0] exp_mv(input logic [7:0] c);
    if (c < 8'h14)
      return 32'd0;
    if (c < 8'h18)
      return 32'd700 + 32'd10 * (c - 8'h14);
    if (c < 8'h9e)
      return 32'd735 + 32'd5 * (c - 8'h18);
    return 32'd1420 + 32'd20 * (c - 8'h9e);
  endfunction

  // Decoded outputs are registered, so they land one edge after the access edge; the check waits two edges
  task check_analog(input logic [7:0] ls, input logic [7:0] va, input logic [7:0] vb);
    repeat (2) @(posedge mclk);
    #1;
    if (ls[5:3] != 3'h7)
      check(32'(analog.peak_limit_ma), 32'd1500 + 32'd500 * ls[5:3], "limit");
    check(32'(analog.peak_limit_valid), 32'(ls[5:3] != 3'h7), "limit ok");
    check(32'(analog.ramp_speed_code), 32'(ls[2:0]), "ramp");
    check(32'(analog.ramp_speed_valid), 32'(ls[2:0] >= 3'h2), "ramp ok");
    check(32'(analog.conv_a_mv), exp_mv(va), "a mv");
    check(32'(analog.conv_a_valid), 32'(va >= 8'h14), "a ok");
    check(32'(analog.conv_b_mv), exp_mv(vb), "b mv");
    check(32'(analog.conv_b_valid), 32'(vb >= 8'h14), "b ok");
  endtask

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    mclk = 1'b0;
    nrst = 1'b0;
    otp_valid = 1'b0;
    otp_limit_slew = 8'h00;
    otp_a_volt = 8'h00;
    otp_b_volt = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`CVSR_IDX_LIMIT_SLEW, 8'h1a);
    rd(`CVSR_IDX_A_VOLT, 8'h00);
    rd(`CVSR_IDX_B_VOLT, 8'h00);
    check_analog(8'h1a, 8'h00, 8'h00);
    // Power-up defaults replace the reset constants
    @(posedge mclk);
    otp_limit_slew <= 8'h2b;
    otp_a_volt <= 8'h14;
    otp_b_volt <= 8'hff;
    otp_valid <= 1'b1;
    n = 0;
    while (otp_loaded !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      n++;
    end
    check(32'(n < 50), 32'd1, "default load");
    if (n >= 50)
      report_and_stop;
    rd(`CVSR_IDX_LIMIT_SLEW, 8'h2b);
    rd(`CVSR_IDX_A_VOLT, 8'h14);
    rd(`CVSR_IDX_B_VOLT, 8'hff);
    check_analog(8'h2b, 8'h14, 8'hff);
    // Every limit and ramp code, spare bits toggled, while running
    for (int c = 0; c < 8; c++)
    begin
      v = {2'(c), 3'(c), 3'(7 - c)};
      wr(`CVSR_IDX_LIMIT_SLEW, v);
      check_analog(v, 8'h14, 8'hff);
      rd(`CVSR_IDX_LIMIT_SLEW, v);
    end
    // Band edges of the setpoint code table, back-to-back writes
    for (int i = 0; i < 7; i++)
    begin
      wr(`CVSR_IDX_A_VOLT, vc[i]);
      wr(`CVSR_IDX_B_VOLT, vc[6 - i]);
      check_analog(v, vc[i], vc[6 - i]);
      rd(`CVSR_IDX_A_VOLT, vc[i]);
      rd(`CVSR_IDX_B_VOLT, vc[6 - i]);
    end
    // Unmapped, misaligned and strobe-less accesses leave the bank alone
    apb(12'h020, 1'b1, 8'h55, 4'hf);
    check(32'(err), 32'd1, "unmapped error");
    apb(12'h015, 1'b0, 8'h00, 4'hf);
    check(32'(err), 32'd1, "misaligned error");
    check(rdata, 32'h0, "misaligned data");
    apb(12'h018, 1'b1, 8'haa, 4'he);
    check(32'(err), 32'd0, "strobe error");
    rd(`CVSR_IDX_A_VOLT, vc[6]);
    rd(`CVSR_IDX_B_VOLT, vc[0]);
    rd(`CVSR_IDX_LIMIT_SLEW, v);
    report_and_stop;
  end
endmodule
`default_nettype wire
